//--- icdsp_consts.svh
// Constants of the I/O cell storage pairs: offsets, fields, reset values, delay counts
`ifndef ICDSP_CONSTS_SVH
`define ICDSP_CONSTS_SVH

// Register byte offsets
`define ICDSP_CTRL_OFS      32'h0000_0000
`define ICDSP_DELAY_OFS     32'h0000_0004
`define ICDSP_ELEM_OFS      32'h0000_0008
`define ICDSP_INVERT_OFS    32'h0000_000c
`define ICDSP_STATUS_OFS    32'h0000_0010

// Control fields
`define ICDSP_CTRL_LOCK     0
`define ICDSP_CTRL_OUT_DDR  1
`define ICDSP_CTRL_TS_DDR   2
`define ICDSP_CTRL_CASCADE  3
`define ICDSP_CTRL_DIFF     4
`define ICDSP_CTRL_OUT_REG  5
`define ICDSP_CTRL_TS_REG   6
`define ICDSP_CTRL_W        7

// Delay fields
`define ICDSP_DLY_ASYNC_LSB 0
`define ICDSP_DLY_REG_LSB   4

// Invert mask fields
`define ICDSP_INV_OUCLK     0
`define ICDSP_INV_OLCLK     1
`define ICDSP_INV_IUCLK     2
`define ICDSP_INV_ILCLK     3
`define ICDSP_INV_OCE       4
`define ICDSP_INV_TCE       5
`define ICDSP_INV_ICE       6
`define ICDSP_INV_SR        7
`define ICDSP_INV_REV       8
`define ICDSP_INV_PAD       9
`define ICDSP_INV_ODATA     10
`define ICDSP_INV_TDATA     11
`define ICDSP_INV_W         12

// Reset values
`define ICDSP_CTRL_RST      7'h00
`define ICDSP_ASYNC_RST     4'h0
`define ICDSP_REG_RST       3'h0
`define ICDSP_ELEM_RST      24'h00_0000
`define ICDSP_INV_RST       12'h000

// Delay line, one tap per clock cycle
`define ICDSP_TAPS          6
`define ICDSP_LINE_LEN      13
`define ICDSP_ASYNC_MAX     4'hc
`define ICDSP_REG_MAX       3'h6
`define ICDSP_REG_AUTO      3'h1
`define ICDSP_REG_HALF      3'h3

// Bus responses
`define ICDSP_RESP_OKAY     2'h0
`define ICDSP_RESP_SLVERR   2'h2

`endif

//--- icdsp_far_end.sv
// Far-side model: link clocks and fabric data bits of one storage pair
`timescale 1ns/1ps
module icdsp_far_end
(
  input  wire logic       run,
  input  wire logic       mirror,
  input  wire logic [1:0] pattern,
  output logic            upper_clock,
  output logic            lower_clock,
  output logic            first_bit,
  output logic            second_bit
);
  initial upper_clock = 1'h0;
  initial second_bit = 1'h0;
  // Clock stands still outside frames
  always
  begin
    #400;
    if (run)
      upper_clock = ~upper_clock;
  end
  assign lower_clock = ~upper_clock;
  assign first_bit = mirror ? 1'h1 : pattern[1];
  // Second bit moved into the lower clock domain
  always @(posedge lower_clock)
    second_bit <= mirror ? 1'h0 : pattern[0];
endmodule : icdsp_far_end

//--- icdsp_io_cell.sv
// I/O cell clocked logic: delay line, six storage elements, DDR muxes, cascade, AXI4-Lite slave
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "icdsp_consts.svh"

// Contract
// - Async fabric input picks one of twelve delays: coarse element plus six taps.
// - Registered path uses three of six taps, six settings with coarse element.
// - Coarse element is used by both paths or bypassed by both.
// - Delay settings are fixed once configured; no change during operation.
// - Async setting ranges zero to twelve, default zero; registered default automatic.
// - Both settings on one pin lie in the same half of the range; here a mismatch is only flagged as half_mismatch.
// - Each of six elements is a flip-flop or a latch independently.
// - Flop loads on edge with enable; latch follows data while enabled.
// - An unconnected clock enable acts as asserted; here the three enable inputs have no default and must be driven.
// - Set/reset forces one or zero per option, synchronous or asynchronous per element.
// - Opposite force gives complement; both together give zero.
// - Output and tristate share upper and lower clocks; input clocks independent.
// - One clock enable per path gates both registers of its pair.
// - One set/reset line and one opposite line control all six elements.
// - Global init loads each element's initial value, by default its force polarity.
// - Output DDR: upper polarity applies to both, initial zero applies to both.
// - Output DDR: first bit on upper clock, second on lower, muxed to pad.
// - Tristate pair supports the same DDR scheme for the driver enable.
// - Input DDR: first bit on upper input clock, second on lower input clock.
// - Cascade re-registers the second input bit on the upper input clock.
// - Cascade exists only for differential pairs and is unreachable from fabric.
// - Every input signal of the cell has a selectable polarity inversion; global_init_pulse has none here.
module icdsp_io_cell
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic [31:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire icdsp_pkg::icdsp_word_type s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [31:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output icdsp_pkg::icdsp_word_type    s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    pad_in,
  output logic                         pad_out,
  output logic                         pad_oe,
  input  wire logic                    output_upper_clock,
  input  wire logic                    output_lower_clock,
  input  wire logic                    input_upper_clock,
  input  wire logic                    input_lower_clock,
  input  wire logic                    out_first_edge_bit,
  input  wire logic                    out_second_edge_bit,
  input  wire logic                    ts_first_edge_bit,
  input  wire logic                    ts_second_edge_bit,
  input  wire logic                    output_pair_clk_en,
  input  wire logic                    tristate_pair_clk_en,
  input  wire logic                    input_pair_clk_en,
  input  wire logic                    set_reset_input,
  input  wire logic                    opposite_force_input,
  input  wire logic                    global_init_pulse,
  output logic                         async_fabric_in,
  output logic                         in_first_edge_bit,
  output logic                         in_second_edge_bit
);
  import icdsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [`ICDSP_CTRL_W-1:0] ctrl;
  icdsp_delay_type          async_set;
  logic [2:0]               reg_set;
  icdsp_elem_cfg_type       elem_cfg [0:5];
  logic [`ICDSP_INV_W-1:0]  inv;
  logic [31:0]              aw_addr;
  logic                     aw_held;
  icdsp_word_type           w_data;
  logic [3:0]               w_strb;
  logic                     w_held;
  logic                     wr_go;
  logic                     wr_hit;
  logic                     rd_hit;
  icdsp_word_type           rd_word;
  icdsp_word_type           cur_word;
  icdsp_word_type           new_word;

  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_comb
  begin
    wr_hit = 1'b1;
    unique case (aw_addr)
      `ICDSP_CTRL_OFS:   cur_word = {25'h000_0000, ctrl};
      `ICDSP_DELAY_OFS:  cur_word = {25'h000_0000, reg_set, async_set};
      `ICDSP_ELEM_OFS:   cur_word = {8'h00, elem_cfg[5], elem_cfg[4], elem_cfg[3],
                                     elem_cfg[2], elem_cfg[1], elem_cfg[0]};
      `ICDSP_INVERT_OFS: cur_word = {20'h0_0000, inv};
      default:
      begin
        cur_word = 32'h0000_0000;
        wr_hit   = 1'b0;
      end
    endcase
    for (int i = 0; i < 4; i++)
      new_word[8*i +: 8] = w_strb[i] ? w_data[8*i +: 8] : cur_word[8*i +: 8];
  end

  // Write channels taken in either order, response after both
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 32'h0000_0000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ICDSP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `ICDSP_RESP_OKAY : `ICDSP_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Configuration writes; lock is sticky until reset
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ctrl      <= `ICDSP_CTRL_RST;
      async_set <= `ICDSP_ASYNC_RST;
      reg_set   <= `ICDSP_REG_RST;
      inv       <= `ICDSP_INV_RST;
      for (int k = 0; k < 6; k++)
        elem_cfg[k] <= 4'(`ICDSP_ELEM_RST >> (4*k));
    end
    else if (wr_go)
    begin
      if (aw_addr == `ICDSP_CTRL_OFS)
        ctrl <= new_word[`ICDSP_CTRL_W-1:0] | {6'h00, ctrl[`ICDSP_CTRL_LOCK]};
      if (aw_addr == `ICDSP_DELAY_OFS && !ctrl[`ICDSP_CTRL_LOCK])
      begin
        if (new_word[3:0] <= `ICDSP_ASYNC_MAX)
          async_set <= new_word[3:0];
        if (new_word[6:4] <= `ICDSP_REG_MAX)
          reg_set <= new_word[6:4];
      end
      if (aw_addr == `ICDSP_ELEM_OFS)
        for (int k = 0; k < 6; k++)
          elem_cfg[k] <= new_word[4*k +: 4];
      if (aw_addr == `ICDSP_INVERT_OFS)
        inv <= new_word[`ICDSP_INV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, polarity inversion and edge finding
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [4:0] pin_pol;
  logic [4:0] pin_rise;

  // Free-running, so the edge finder holds each pin's idle level when reset ends
  always_ff @(posedge clk)
  begin
    sync1 <= {pad_in, input_lower_clock, input_upper_clock, output_lower_clock, output_upper_clock};
    sync2 <= sync1;
    sync3 <= pin_pol;
  end

  assign pin_pol  = sync2 ^ {inv[`ICDSP_INV_PAD], inv[`ICDSP_INV_ILCLK], inv[`ICDSP_INV_IUCLK],
                             inv[`ICDSP_INV_OLCLK], inv[`ICDSP_INV_OUCLK]};
  assign pin_rise = pin_pol & ~sync3;

  ////////////////////////////////////////////////////////////////////////////
  // Input delay line: tap k is k cycles, coarse element is six
  logic [`ICDSP_LINE_LEN-1:0] line;
  logic [`ICDSP_LINE_LEN-1:1] line_q;
  logic                       coarse_used;
  logic [2:0]                 reg_tap;
  logic [3:0]                 reg_index;
  logic                       half_mismatch;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      line_q <= 12'h000;
    else
      line_q <= line[`ICDSP_LINE_LEN-2:0];
  end

  assign line        = {line_q, pin_pol[4]};
  assign coarse_used = async_set > 4'(`ICDSP_TAPS);
  assign reg_tap     = (reg_set == 3'h0) ? `ICDSP_REG_AUTO :
                       (reg_set > `ICDSP_REG_HALF) ? reg_set - `ICDSP_REG_HALF : reg_set;
  assign reg_index   = (coarse_used ? 4'(`ICDSP_TAPS) : 4'h0) + {reg_tap, 1'b0};
  assign half_mismatch = (reg_set != 3'h0) && (async_set != 4'h0) &&
                         ((reg_set > `ICDSP_REG_HALF) != coarse_used);

  ////////////////////////////////////////////////////////////////////////////
  // Six storage elements: 0/1 output, 2/3 tristate, 4/5 input
  logic el_q     [0:5];
  logic el_level [0:5];
  logic el_rise  [0:5];
  logic el_ce    [0:5];
  logic el_d     [0:5];
  logic el_srhi  [0:5];
  logic el_init  [0:5];
  logic sr_in;
  logic rev_in;
  logic frc_val  [0:5];

  assign sr_in  = set_reset_input ^ inv[`ICDSP_INV_SR];
  assign rev_in = opposite_force_input ^ inv[`ICDSP_INV_REV];

  // Shared clocks and enables per pair
  always_comb
  begin
    el_level = '{pin_pol[0], pin_pol[1], pin_pol[0], pin_pol[1], pin_pol[2], pin_pol[3]};
    el_rise  = '{pin_rise[0], pin_rise[1], pin_rise[0], pin_rise[1], pin_rise[2], pin_rise[3]};
    el_ce[0] = output_pair_clk_en ^ inv[`ICDSP_INV_OCE];
    el_ce[1] = el_ce[0];
    el_ce[2] = tristate_pair_clk_en ^ inv[`ICDSP_INV_TCE];
    el_ce[3] = el_ce[2];
    el_ce[4] = input_pair_clk_en ^ inv[`ICDSP_INV_ICE];
    el_ce[5] = el_ce[4];
    el_d[0]  = out_first_edge_bit ^ inv[`ICDSP_INV_ODATA];
    el_d[1]  = out_second_edge_bit ^ inv[`ICDSP_INV_ODATA];
    el_d[2]  = ts_first_edge_bit ^ inv[`ICDSP_INV_TDATA];
    el_d[3]  = ts_second_edge_bit ^ inv[`ICDSP_INV_TDATA];
    el_d[4]  = line[reg_index];
    el_d[5]  = line[reg_index];
    for (int k = 0; k < 6; k++)
    begin
      el_srhi[k] = elem_cfg[k].force_one_select;
      el_init[k] = elem_cfg[k].init;
    end
    // DDR pairs follow the upper polarity; an initial zero covers both
    if (ctrl[`ICDSP_CTRL_OUT_DDR])
    begin
      el_srhi[1] = elem_cfg[0].force_one_select;
      el_init[0] = elem_cfg[0].init & elem_cfg[1].init;
      el_init[1] = el_init[0];
    end
    if (ctrl[`ICDSP_CTRL_TS_DDR])
    begin
      el_srhi[3] = elem_cfg[2].force_one_select;
      el_init[2] = elem_cfg[2].init & elem_cfg[3].init;
      el_init[3] = el_init[2];
    end
    for (int k = 0; k < 6; k++)
      frc_val[k] = (sr_in && rev_in) ? 1'b0 : (sr_in ? el_srhi[k] : !el_srhi[k]);
  end

  for (genvar k = 0; k < 6; k++)
  begin : g_elem
    logic tick;

    assign tick = elem_cfg[k].latch ? el_level[k] : el_rise[k];

    always_ff @(posedge clk)
    begin
      if (!nrst)
        el_q[k] <= 1'b0;
      else if (global_init_pulse)
        el_q[k] <= el_init[k];
      else if ((sr_in || rev_in) && (!elem_cfg[k].sync || tick))
        el_q[k] <= frc_val[k];
      else if (tick && el_ce[k])
        el_q[k] <= el_d[k];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cascade, DDR muxes and fabric outputs
  logic cascade_on;
  logic casc_q;

  assign cascade_on = ctrl[`ICDSP_CTRL_CASCADE] && ctrl[`ICDSP_CTRL_DIFF];

  always_ff @(posedge clk)
  begin
    if (!nrst)
      casc_q <= 1'b0;
    else if (pin_rise[2])
      casc_q <= el_q[5];
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pad_out            <= 1'b0;
      pad_oe             <= 1'b0;
      async_fabric_in    <= 1'b0;
      in_first_edge_bit  <= 1'b0;
      in_second_edge_bit <= 1'b0;
    end
    else
    begin
      if (ctrl[`ICDSP_CTRL_OUT_DDR])
        pad_out <= pin_pol[0] ? el_q[0] : el_q[1];
      else
        pad_out <= ctrl[`ICDSP_CTRL_OUT_REG] ? el_q[0] : el_d[0];
      // Tristate value high floats the driver
      if (ctrl[`ICDSP_CTRL_TS_DDR])
        pad_oe <= !(pin_pol[0] ? el_q[2] : el_q[3]);
      else
        pad_oe <= !(ctrl[`ICDSP_CTRL_TS_REG] ? el_q[2] : el_d[2]);
      async_fabric_in    <= line[async_set];
      in_first_edge_bit  <= el_q[4];
      in_second_edge_bit <= cascade_on ? casc_q : el_q[5];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `ICDSP_CTRL_OFS:   rd_word = {25'h000_0000, ctrl};
      `ICDSP_DELAY_OFS:  rd_word = {25'h000_0000, reg_set, async_set};
      `ICDSP_ELEM_OFS:   rd_word = {8'h00, elem_cfg[5], elem_cfg[4], elem_cfg[3],
                                    elem_cfg[2], elem_cfg[1], elem_cfg[0]};
      `ICDSP_INVERT_OFS: rd_word = {20'h0_0000, inv};
      `ICDSP_STATUS_OFS: rd_word = {20'h0_0000, reg_index, half_mismatch, casc_q,
                                    el_q[5], el_q[4], el_q[3], el_q[2], el_q[1], el_q[0]};
      default:
      begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ICDSP_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? `ICDSP_RESP_OKAY : `ICDSP_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  async_tap_a: assert property ($stable(async_set) |=> async_fabric_in == $past(line[async_set]))
    else $error("async delay tap wrong");
  reg_tap_a: assert property (reg_index <= 4'(`ICDSP_LINE_LEN - 1) && reg_index[0] == 1'b0)
    else $error("registered tap out of set");
  coarse_share_a: assert property (coarse_used == (reg_index > 4'(`ICDSP_TAPS)))
    else $error("coarse element not shared");
  delay_lock_a: assert property (ctrl[`ICDSP_CTRL_LOCK] |=> $stable(async_set) && $stable(reg_set))
    else $error("delay changed while locked");
  async_range_a: assert property (async_set <= `ICDSP_ASYNC_MAX)
    else $error("async delay out of range");
  both_force_a: assert property (sr_in && rev_in && !global_init_pulse && !elem_cfg[0].sync
                                 |=> !el_q[0])
    else $error("both forces did not give zero");
  ce_hold_a: assert property (!el_ce[4] && !sr_in && !rev_in && !global_init_pulse
                              |=> $stable(el_q[4]))
    else $error("element moved with enable low");
  init_load_a: assert property (global_init_pulse |=> el_q[2] == $past(el_init[2]))
    else $error("init value not loaded");
  cascade_a: assert property (pin_rise[2] |=> casc_q == $past(el_q[5]))
    else $error("cascade not re-registered");
  ddr_mux_a: assert property (ctrl[`ICDSP_CTRL_OUT_DDR]
                              |=> pad_out == ($past(pin_pol[0]) ? $past(el_q[0]) : $past(el_q[1])))
    else $error("DDR mux chose wrong bit");

  ddr_out_c: cover property (ctrl[`ICDSP_CTRL_OUT_DDR] && pin_rise[1] && el_ce[1]);
  cascade_c: cover property (cascade_on && pin_rise[2]);
  latch_c: cover property (elem_cfg[4].latch && el_level[4] && el_ce[4]);
  bad_half_c: cover property (half_mismatch);

endmodule : icdsp_io_cell

//--- icdsp_pkg.sv
// Types of the I/O cell storage pairs
package icdsp_pkg;
  typedef logic [31:0] icdsp_word_type;
  typedef logic [3:0]  icdsp_delay_type;
  typedef struct packed {
    logic latch;
    logic sync;
    logic force_one_select;
    logic init;
  } icdsp_elem_cfg_type;
endpackage : icdsp_pkg

//--- io_cell_ddr_storage_pairs_tb.sv
// Testbench of the I/O cell storage pairs
`timescale 1ns/1ps
module io_cell_ddr_storage_pairs_tb;
  import icdsp_pkg::*;
  logic clk = 1'h0, nrst = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_araddr = 32'h0;
  icdsp_word_type s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, pat = 2'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pad_out, pad_oe;
  logic pad_in = 1'h0, ts_first_edge_bit = 1'h0, ts_second_edge_bit = 1'h0, global_init_pulse = 1'h0;
  logic output_pair_clk_en = 1'h1, tristate_pair_clk_en = 1'h1, input_pair_clk_en = 1'h1;
  logic set_reset_input = 1'h0, opposite_force_input = 1'h0, run0 = 1'h0, run1 = 1'h0, mir = 1'h0;
  logic output_upper_clock, output_lower_clock, input_upper_clock, input_lower_clock;
  logic out_first_edge_bit, out_second_edge_bit, async_fabric_in, in_first_edge_bit, in_second_edge_bit;
  int n_errors = 0, compares = 0, cycles = 0;
  icdsp_io_cell dut_u
  (
    .clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out, .pad_oe, .output_upper_clock,
    .output_lower_clock, .input_upper_clock, .input_lower_clock, .out_first_edge_bit, .out_second_edge_bit,
    .ts_first_edge_bit, .ts_second_edge_bit, .output_pair_clk_en, .tristate_pair_clk_en, .input_pair_clk_en,
    .set_reset_input, .opposite_force_input, .global_init_pulse, .async_fabric_in, .in_first_edge_bit,
    .in_second_edge_bit
  );
  icdsp_far_end out_side_u
  (
    .run(run0), .mirror(mir), .pattern(pat), .upper_clock(output_upper_clock),
    .lower_clock(output_lower_clock), .first_bit(out_first_edge_bit), .second_bit(out_second_edge_bit)
  );
  icdsp_far_end in_side_u
  (
    .run(run1), .mirror(1'h0), .pattern(2'h0), .upper_clock(input_upper_clock),
    .lower_clock(input_lower_clock), .first_bit(), .second_bit()
  );
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask : axi_write
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : axi_read
  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////
  task automatic regs_test;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++)
    begin
      axi_read(32'(4 * i), d, r);
      check(d, 32'h0, "reset value");
    end
    axi_read(32'h14, d, r);
    check({30'h0, r}, 32'h2, "unmapped response");
    axi_write(32'h4, 32'hd);
    check({30'h0, s_axi_bresp}, 32'h0, "write response okay");
    axi_write(32'h14, 32'h1);
    check({30'h0, s_axi_bresp}, 32'h2, "unmapped write response");
    axi_read(32'h4, d, r);
    check(d, 32'h0, "async setting above range");
  endtask : regs_test
  task automatic measure(input logic [3:0] s, output int n);
    axi_write(32'h4, {28'h0, s});
    repeat (30) @(posedge clk);
    n = 0;
    pad_in <= ~pad_in;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (async_fabric_in !== pad_in && n < 100);
  endtask : measure
  task automatic delay_test;
    int n0;
    int n12;
    logic [31:0] d;
    logic [1:0] r;
    measure(4'h0, n0);
    measure(4'hc, n12);
    check(32'(n12 - n0), 32'hc, "twelve delay steps");
    axi_write(32'h0, 32'h1);
    axi_write(32'h4, 32'h3);
    axi_read(32'h4, d, r);
    check(d, 32'hc, "delay fixed after lock");
  endtask : delay_test
  task automatic half_check(input logic hi, input logic lo);
    @(posedge output_upper_clock);
    repeat (6) @(posedge clk);
    check({31'h0, pad_out}, {31'h0, hi}, "pad upper half");
    check({31'h0, pad_oe}, 32'h1, "driver on upper half");
    @(negedge output_upper_clock);
    repeat (6) @(posedge clk);
    check({31'h0, pad_out}, {31'h0, lo}, "pad lower half");
    check({31'h0, pad_oe}, 32'h0, "driver off lower half");
  endtask : half_check
  task automatic ddr_out_test;
    axi_write(32'h0, 32'h66);
    ts_second_edge_bit <= 1'h1;
    pat <= 2'h2;
    run0 <= 1'h1;
    repeat (2) @(posedge output_upper_clock);
    half_check(1'h1, 1'h0);
    mir <= 1'h1;
    pat <= 2'h1;
    repeat (2) @(posedge output_upper_clock);
    half_check(1'h1, 1'h0);
    mir <= 1'h0;
    output_pair_clk_en <= 1'h0;
    repeat (2) @(posedge output_upper_clock);
    half_check(1'h1, 1'h0);
    output_pair_clk_en <= 1'h1;
    repeat (2) @(posedge output_upper_clock);
    half_check(1'h0, 1'h1);
    run0 <= 1'h0;
  endtask : ddr_out_test
  task automatic ddr_in_round(input logic lvl, input string what);
    repeat (4)
    begin
      @(negedge input_upper_clock);
      @(posedge clk);
      pad_in <= lvl;
      @(posedge input_upper_clock);
      @(posedge clk);
      pad_in <= !lvl;
    end
    repeat (6) @(posedge clk);
    check({31'h0, in_first_edge_bit}, {31'h0, lvl}, what);
    check({31'h0, in_second_edge_bit}, {31'h0, !lvl}, what);
  endtask : ddr_in_round
  task automatic force_test;
    logic [31:0] d;
    logic [1:0] r;
    axi_write(32'h8, 32'h222222);
    set_reset_input <= 1'h1;
    axi_read(32'h10, d, r);
    check(d & 32'h3f, 32'h3f, "async set of all six");
    opposite_force_input <= 1'h1;
    axi_read(32'h10, d, r);
    check(d & 32'h3f, 32'h0, "both forces give zero");
    set_reset_input <= 1'h0;
    axi_read(32'h10, d, r);
    check(d & 32'h3f, 32'h0, "opposite force alone");
    opposite_force_input <= 1'h0;
    axi_write(32'h8, 32'h666666);
    set_reset_input <= 1'h1;
    axi_read(32'h10, d, r);
    check(d & 32'h3f, 32'h0, "sync force waits for clock");
    run0 <= 1'h1;
    repeat (2) @(posedge output_upper_clock);
    run0 <= 1'h0;
    axi_read(32'h10, d, r);
    check(d & 32'hf, 32'hf, "sync force on clock");
    set_reset_input <= 1'h0;
    axi_write(32'h8, 32'h333333);
    global_init_pulse <= 1'h1;
    axi_read(32'h10, d, r);
    check(d & 32'h3f, 32'h3f, "initial values loaded");
    global_init_pulse <= 1'h0;
    axi_write(32'h4, 32'h1c);
    axi_read(32'h10, d, r);
    check(d & 32'hf80, 32'h880, "half mismatch and coarse tap");
  endtask : force_test
  ////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    regs_test();
    delay_test();
    do_reset();
    ddr_out_test();
    run1 <= 1'h1;
    ddr_in_round(1'h1, "input pair capture");
    axi_write(32'h0, 32'h7e);
    ddr_in_round(1'h0, "cascaded capture");
    run1 <= 1'h0;
    force_test();
    complete_run();
  end
endmodule : io_cell_ddr_storage_pairs_tb
